/* File: verilog/dac_ctrl_pkg.sv */
// constants and types shared by the octal converter control block
// assumes a single 25 MHz system clock domain
package dac_ctrl_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int CH_NUM = 8;
    localparam int CODE_W = 10;
    localparam int CNT_W = 4;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 25;
    localparam int T_STARTUP_US = 5000;
    localparam int STARTUP_CYC = T_STARTUP_US * CLK_MHZ;
    localparam int STARTUP_W = 17;

    // ****************************************
    // bus addressing
    // ****************************************
    localparam logic [3:0] ADDR_HI = 4'h9;
    localparam logic [6:0] BCAST_ADDR = 7'h47;
    localparam logic [7:0] GC_ADDR = 8'h00;
    localparam logic [7:0] GC_RESET = 8'h06;
    localparam logic [2:0] STRAP_GND = 3'h0;
    localparam logic [2:0] STRAP_VDD = 3'h1;
    localparam logic [2:0] STRAP_SDA = 3'h2;
    localparam logic [2:0] STRAP_SCL = 3'h3;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] ACK_CNT = 4'h9;

    // ****************************************
    // command byte and register layout
    // ****************************************
    localparam logic [7:0] CMD_CFG = 8'h01;
    localparam logic [7:0] CMD_TRIG = 8'h02;
    localparam logic [7:0] CMD_BCAST = 8'h03;
    localparam logic [4:0] CMD_CH_HI = 5'h01;
    localparam int CODE_LSB = 2;
    localparam int SWRST_W = 4;
    localparam logic [SWRST_W-1:0] SWRST_CODE = 4'ha;
    localparam logic [CH_NUM-1:0] PD_RESET = 8'hff;

    // ****************************************
    // types
    // ****************************************
    typedef logic [CH_NUM-1:0][CODE_W-1:0] code_arr_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
    } bus_ev_s;

    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_addr = 3'h1,
        st_cmd = 3'h3,
        st_msb = 3'h2,
        st_lsb = 3'h6,
        st_read = 3'h7,
        st_gcall = 3'h5,
        st_ignore = 3'h4
    } bus_state_e;

endpackage : dac_ctrl_pkg

/* File: verilog/pin_sync.sv */
// two flip-flop synchroniser for a group of pins
// assumes asynchronous active-low reset; idle level given by parameter
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= IDLE;
            dout <= IDLE;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule : pin_sync

/* File: verilog/channel_bank.sv */
// buffer and active code registers for all channels
// assumes arst_n already combines system reset and the clear pin
`timescale 1ns/1ps
module channel_bank import dac_ctrl_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control
    input wire logic soft_clr,
    input wire logic [CH_NUM-1:0] wr_en,
    input wire logic [CODE_W-1:0] wr_code,
    input wire logic [CH_NUM-1:0] load_one,
    input wire logic load_all,
    // codes
    output code_arr_t buf_code,
    output code_arr_t active_code
);

    for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_ch
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                buf_code[ch] <= '0; // R7
                active_code[ch] <= '0; // R3
            end else if (soft_clr) begin
                buf_code[ch] <= '0; // R3
                active_code[ch] <= '0;
            end else begin
                if (wr_en[ch])
                    buf_code[ch] <= wr_code; // R4
                if (load_one[ch])
                    active_code[ch] <= wr_code; // R5
                else if (load_all)
                    active_code[ch] <= buf_code[ch]; // R6
            end
        end
    end

endmodule : channel_bank

/* File: verilog/octal_dac_ctrl.sv */
// two-wire slave and update control of an eight-channel converter
// assumes pins are asynchronous to sys_clk; open-drain data pin resolved outside
// Function
// [R1] channel codes are plain unsigned binary
// [R2] code width is 10 bits, zero to all ones
// [R3] power-on or any reset zeroes every channel register
// [R4] writes go to a buffer, then copy to the active register
// [R5] strobe low before write: active loads at end of frame
// [R6] strobe high: buffer holds until strobe falls, then all load
// [R7] clear pin low zeroes buffers and active registers asynchronously
// [R8] reset restores defaults; master waits 5 ms before talking
// [R9] after power-up outputs stay put until a channel is written
// [R10] code 1010 in the trigger register reset field resets all
// [R11] amplifiers power down per channel by configuration bits
// [R12] all channels start powered down until a 0 is written
// [R13] master makes the clock, start, stop and addressing
// [R14] slave receives on writes, returns registers on reads
// [R15] works at standard, fast and fast-plus bit rates
// [R16] only 7-bit addresses are recognised
// [R17] general call 0x00 then 0x06 resets the device
// [R18] general call reset fires on the acknowledge rising clock
// [R19] receiver acknowledges by holding data low on ninth clock
// [R20] address is 1001 plus three bits set by the strap pin
// [R21] frame is address, command, upper and lower byte, each acked
// [R22] command selects configuration, trigger, broadcast, channels A to H
// [R23] broadcast address 1000111 accepted for writes regardless of strap
// [R24] strobe level sampled when a channel write starts
`timescale 1ns/1ps
module octal_dac_ctrl import dac_ctrl_pkg::*; #(
    parameter int STARTUP_CYCLES = STARTUP_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // control pins
    input wire logic address_strap,
    input wire logic load_strobe_n,
    input wire logic clear_input_n,
    // converter side
    output code_arr_t active_code,
    output logic [CH_NUM-1:0] power_down
);

    // ****************************************
    // pin synchronisers and edge events
    // ****************************************
    logic [3:0] pins_s;
    logic scl_s, sda_s, strap_s, strobe_s;
    logic scl_q, sda_q, strobe_q;
    bus_ev_s ev;
    logic strobe_fall;

    pin_sync #(.WIDTH(4), .IDLE(4'hf)) u_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .din({scl_in, sda_in, address_strap, load_strobe_n}),
        .dout(pins_s)
    );

    assign scl_s = pins_s[3];
    assign sda_s = pins_s[2];
    assign strap_s = pins_s[1];
    assign strobe_s = pins_s[0];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            strobe_q <= 1'b1;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            strobe_q <= strobe_s;
        end
    end

    // master owns clock and framing; slave only observes them
    assign ev.start = scl_s & scl_q & sda_q & ~sda_s; // R13
    assign ev.stop = scl_s & scl_q & ~sda_q & sda_s;
    assign ev.scl_rise = scl_s & ~scl_q; // R15
    assign ev.scl_fall = ~scl_s & scl_q;
    assign strobe_fall = strobe_q & ~strobe_s;

    // ****************************************
    // start-up hold off
    // ****************************************
    logic [STARTUP_W-1:0] boot_cnt;
    logic ready;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_cnt <= '0;
            ready <= 1'b0;
        end else if (!ready) begin
            boot_cnt <= boot_cnt + 1'b1;
            ready <= (boot_cnt >= STARTUP_W'(STARTUP_CYCLES - 1)); // R8
        end
    end

    // ****************************************
    // bus state
    // ****************************************
    bus_state_e state, next_state;
    logic [CNT_W-1:0] bit_cnt;
    logic [7:0] shreg, cmd, msb_byte;
    logic ack_ok, next_ack, mack, rd_hi, sync_mode;
    logic [15:0] rd_word, rd_mux;
    logic r_low, f_high, mism_sda;
    logic [2:0] strap_code;
    logic [CH_NUM-1:0] pending;
    logic [CODE_W-1:0] bcast_code;
    code_arr_t buf_code;

    // strap: ground, supply, data or clock, judged over the address byte
    assign strap_code = !r_low ? (f_high ? STRAP_VDD : STRAP_SCL)
                      : (mism_sda ? STRAP_GND : STRAP_SDA); // R20

    logic addr_hit, bcast_hit, gcall_hit, cmd_is_ch, cmd_valid;
    assign addr_hit = shreg[7:1] == {ADDR_HI, strap_code}; // R16
    assign bcast_hit = shreg[7:1] == BCAST_ADDR && !shreg[0]; // R23
    assign gcall_hit = shreg == GC_ADDR;
    assign cmd_is_ch = cmd[7:3] == CMD_CH_HI;
    assign cmd_valid = shreg == CMD_CFG || shreg == CMD_TRIG || shreg == CMD_BCAST
                     || shreg[7:3] == CMD_CH_HI; // R22

    always_comb begin
        case (state)
            st_addr: next_ack = addr_hit || bcast_hit || gcall_hit;
            st_cmd: next_ack = cmd_valid;
            st_msb, st_lsb: next_ack = 1'b1; // R21
            st_gcall: next_ack = shreg == GC_RESET;
            default: next_ack = 1'b0;
        endcase
    end

    logic ack_start, ack_end, ack_rise;
    assign ack_start = ev.scl_fall && bit_cnt == DATA_BITS;
    assign ack_end = ev.scl_fall && bit_cnt == ACK_CNT;
    assign ack_rise = ev.scl_rise && bit_cnt == DATA_BITS;

    always_comb begin
        case (state)
            st_addr:
                if (!ack_ok)
                    next_state = st_ignore;
                else if (gcall_hit)
                    next_state = st_gcall;
                else if (shreg[0])
                    next_state = st_read; // R14
                else
                    next_state = st_cmd;
            st_cmd: next_state = ack_ok ? st_msb : st_ignore;
            st_msb: next_state = st_lsb;
            st_lsb: next_state = st_msb;
            st_read: next_state = mack ? st_ignore : st_read;
            default: next_state = st_ignore;
        endcase
    end

    // ****************************************
    // register access decode
    // ****************************************
    logic wr_fire, soft_rst, gc_fire, wr_ch_cmd;
    logic [15:0] wdata;
    logic [CODE_W-1:0] wcode;
    logic [CH_NUM-1:0] wr_en, load_one;
    assign wdata = {msb_byte, shreg};
    assign wcode = wdata[CODE_LSB +: CODE_W]; // R1 R2
    assign wr_fire = ack_end && state == st_lsb && ack_ok; // R21
    assign wr_ch_cmd = wr_fire && cmd_is_ch;
    assign gc_fire = ack_rise && state == st_gcall && ack_ok; // R18 R17
    assign soft_rst = gc_fire || (wr_fire && cmd == CMD_TRIG
                      && wdata[SWRST_W-1:0] == SWRST_CODE); // R10
    assign wr_en = wr_ch_cmd ? CH_NUM'(1) << cmd[2:0]
                 : {CH_NUM{wr_fire && cmd == CMD_BCAST}};
    assign load_one = wr_en & {CH_NUM{!sync_mode}}; // R5

    always_comb begin
        case (cmd)
            CMD_CFG: rd_mux = {8'h00, power_down};
            CMD_TRIG: rd_mux = {7'h00, strobe_s, pending};
            CMD_BCAST: rd_mux = 16'(bcast_code) << CODE_LSB;
            default: rd_mux = cmd_is_ch ? 16'(buf_code[cmd[2:0]]) << CODE_LSB : 16'h0000;
        endcase
    end

    logic [7:0] tx_byte;
    logic [2:0] tx_idx;
    assign tx_byte = rd_hi ? rd_word[15:8] : rd_word[7:0];
    assign tx_idx = 3'(7 - bit_cnt);

    // first bit of the next read byte, sent on the end of the acknowledge
    logic tx_next_bit;
    assign tx_next_bit = (state == st_read) ? (rd_hi ? rd_word[7] : rd_word[15]) : rd_mux[15];

    // ****************************************
    // bus sequencer
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= st_idle;
            bit_cnt <= '0;
            shreg <= '0;
            ack_ok <= 1'b0;
            mack <= 1'b0;
            sda_oe <= 1'b0;
        end else if (!ready || ev.stop) begin
            state <= st_idle;
            sda_oe <= 1'b0;
        end else if (ev.start) begin
            state <= st_addr; // R13
            bit_cnt <= '0;
            sda_oe <= 1'b0;
        end else if (state != st_idle && state != st_ignore) begin
            if (ev.scl_rise && bit_cnt < DATA_BITS) begin
                shreg <= {shreg[6:0], sda_s};
                bit_cnt <= bit_cnt + 1'b1;
            end else if (ack_rise) begin
                bit_cnt <= ACK_CNT;
                mack <= sda_s; // master nack ends the read
            end
            if (ack_start) begin
                ack_ok <= next_ack;
                sda_oe <= (state != st_read) && next_ack; // R19
            end else if (ack_end) begin
                bit_cnt <= '0;
                state <= next_state;
                sda_oe <= (next_state == st_read) && !tx_next_bit;
            end else if (ev.scl_fall && state == st_read && bit_cnt != '0) begin
                sda_oe <= !tx_byte[tx_idx]; // R14
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_word <= '0;
            rd_hi <= 1'b1;
        end else if (ack_end && next_state == st_read) begin
            if (state != st_read) begin
                rd_word <= rd_mux;
                rd_hi <= 1'b1;
            end else
                rd_hi <= !rd_hi;
        end
    end

    // ****************************************
    // strap detection over the address byte
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_low <= 1'b0;
            f_high <= 1'b0;
            mism_sda <= 1'b0;
        end else if (ev.start) begin
            r_low <= 1'b0;
            f_high <= 1'b0;
            mism_sda <= 1'b0;
        end else if (state == st_addr && bit_cnt < DATA_BITS) begin
            if (ev.scl_rise) begin
                r_low <= r_low | !strap_s; // R20
                mism_sda <= mism_sda | (strap_s != sda_s);
            end
            if (ev.scl_fall)
                f_high <= f_high | strap_s;
        end
    end

    // ****************************************
    // command and data capture
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= '0;
            msb_byte <= '0;
            sync_mode <= 1'b1;
        end else if (ack_end) begin
            if (state == st_cmd)
                cmd <= shreg;
            if (state == st_msb)
                msb_byte <= shreg;
            if (state == st_cmd || state == st_lsb)
                sync_mode <= strobe_s; // R24
        end
    end

    // ****************************************
    // configuration, pending and broadcast registers
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_down <= PD_RESET; // R12
            pending <= '0;
            bcast_code <= '0;
        end else if (soft_rst) begin
            power_down <= PD_RESET; // R8
            pending <= '0;
            bcast_code <= '0;
        end else begin
            if (wr_fire && cmd == CMD_CFG)
                power_down <= wdata[CH_NUM-1:0]; // R11
            if (wr_fire && cmd == CMD_BCAST)
                bcast_code <= wcode;
            pending <= (pending & ~{CH_NUM{strobe_fall}}) | (wr_en & {CH_NUM{sync_mode}}); // R6
        end
    end

    // ****************************************
    // channel registers
    // ****************************************
    logic bank_rst_n;
    assign bank_rst_n = rst_n & clear_input_n; // R7

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            sda_out <= 1'b0;
        else
            sda_out <= 1'b0;
    end

    channel_bank u_bank (
        .clk(sys_clk),
        .arst_n(bank_rst_n),
        .soft_clr(soft_rst), // R3
        .wr_en(wr_en), // R4
        .wr_code(wcode),
        .load_one(load_one),
        .load_all(strobe_fall), // R6
        .buf_code(buf_code),
        .active_code(active_code) // R9
    );

endmodule : octal_dac_ctrl

/* File: testbench/octal_dac_ctrl_properties.sv */
// pin-level assertions for the octal converter control block
// assumes one sys_clk domain and rst_n active low
`timescale 1ns/1ps
module octal_dac_ctrl_properties import dac_ctrl_pkg::*; #(
    parameter int STARTUP_CYCLES = STARTUP_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // pins and outputs
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic address_strap,
    input wire logic load_strobe_n,
    input wire logic clear_input_n,
    input wire code_arr_t active_code,
    input wire logic [CH_NUM-1:0] power_down
);
    int cyc;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) cyc <= 0;
        else if (cyc < STARTUP_CYCLES) cyc <= cyc + 1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence ack_held;
        sda_oe [*2];
    endsequence
    sequence strobe_idle_hi;
        load_strobe_n [*6];
    endsequence
    AST_DRIVE_LOW_ONLY: assert property (sda_oe |-> !sda_out)
        else $error("data pin driven high");
    AST_CLEAR_ZEROES: assert property (!clear_input_n |=> active_code == '0)
        else $error("clear did not zero codes");
    AST_ACK_STARTS_LOW: assert property ($rose(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 2))
        else $error("data pin taken while clock high");
    AST_ACK_HOLDS: assert property ($rose(scl_in) && sda_oe |=> ack_held)
        else $error("data pin let go in clock high phase");
    AST_RESET_DEFAULTS: assert property ($rose(rst_n) |-> active_code == '0 && power_down == PD_RESET)
        else $error("wrong values after reset");
    AST_STARTUP_SILENT: assert property (cyc < STARTUP_CYCLES |-> !sda_oe)
        else $error("bus answered during start-up");
    AST_SYNC_HOLDS: assert property (strobe_idle_hi ##0 ($changed(active_code) && active_code != '0)
        |-> !scl_in || !$past(scl_in, 2))
        else $error("code changed outside an update point");
    AST_PD_AT_ACK_FALL: assert property ($changed(power_down) && power_down != PD_RESET
        |-> !scl_in || !$past(scl_in, 2))
        else $error("power down changed outside an update point");
endmodule : octal_dac_ctrl_properties
bind octal_dac_ctrl octal_dac_ctrl_properties #(.STARTUP_CYCLES(STARTUP_CYCLES)) props (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap(address_strap), .load_strobe_n(load_strobe_n), .clear_input_n(clear_input_n),
    .active_code(active_code), .power_down(power_down)
);

/* File: testbench/bus_master_model.sv */
// two-wire bus master that talks to the converter control block
// assumes a 40 ns clk; one bit lasts 8 cycles, 320 ns
`timescale 1ns/1ps
module bus_master_model (
    // clock
    input wire logic clk,
    // device side of the data pin
    input wire logic dev_oe,
    input wire logic dev_val,
    // resolved wires
    output logic scl,
    output logic sda
);
    logic sda_drv = 1'b1;
    initial scl = 1'b1;
    // pull-up resolves both open-drain drivers
    assign sda = sda_drv & (dev_oe ? dev_val : 1'b1);
    task automatic half();
        repeat (4) @(posedge clk);
    endtask : half
    task automatic start();
        sda_drv <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        sda_drv <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_drv <= 1'b1;
        half();
    endtask : stop
    task automatic bit_io(input logic b, output logic r);
        sda_drv <= b;
        half();
        scl <= 1'b1;
        repeat (2) @(posedge clk);
        r = sda;
        repeat (2) @(posedge clk);
        scl <= 1'b0;
    endtask : bit_io
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : put_byte
    // acks every byte except the last of a read
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask : get_byte
endmodule : bus_master_model

/* File: testbench/testbench.sv */
// self-checking bench for the octal converter control block
// assumes the bus master model and the bound property checker
`timescale 1ns/1ps
module testbench import dac_ctrl_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic load_strobe_n = 1'b0;
    logic clear_input_n = 1'b1;
    logic address_strap = 1'b0;
    logic scl;
    logic sda;
    logic sda_out;
    logic sda_oe;
    code_arr_t active_code;
    logic [CH_NUM-1:0] power_down;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    always #20 sys_clk = ~sys_clk;
    bus_master_model mst (.clk(sys_clk), .dev_oe(sda_oe), .dev_val(sda_out), .scl(scl), .sda(sda));
    octal_dac_ctrl #(.STARTUP_CYCLES(20)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_strap(address_strap), .load_strobe_n(load_strobe_n), .clear_input_n(clear_input_n),
        .active_code(active_code), .power_down(power_down)
    );
    // ****************************************
    // helpers
    // ****************************************
    task automatic report_and_stop();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t %s: got %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check
    function automatic logic [15:0] word(input logic [9:0] code);
        return {4'h0, code, 2'b00};
    endfunction : word
    function automatic logic [9:0] code_of(input int ch);
        return {~ch[2:0], 7'h7f};
    endfunction : code_of
    task automatic frame(input logic [7:0] addr, input logic [7:0] cmd, input logic [15:0] w);
        logic [3:0] a;
        mst.start();
        mst.put_byte(addr, a[3]);
        mst.put_byte(cmd, a[2]);
        mst.put_byte(w[15:8], a[1]);
        mst.put_byte(w[7:0], a[0]);
        mst.stop();
        check(16'(a), 16'h000f, "frame acks");
    endtask : frame
    task automatic zeros(input string what);
        check(16'(active_code !== '0), 16'h0, what);
        check(16'(power_down), 16'h00ff, what);
    endtask : zeros
    task automatic t_refuse();
        logic [7:0] bad [3] = '{8'h92, 8'h8f, 8'hf0};
        logic ack;
        for (int i = 0; i < 3; i++) begin
            mst.start();
            mst.put_byte(bad[i], ack);
            mst.stop();
            check(16'(ack), 16'h0, "refused header");
        end
        frame(8'h8e, 8'h0b, word(10'h123));
        check(16'(active_code[3]), 16'h0123, "broadcast write");
        $display("refuse done");
    endtask : t_refuse
    task automatic t_async();
        for (int i = 0; i < CH_NUM; i++) frame(8'h90, 8'(8'h08 + i), word(code_of(i)));
        for (int i = 0; i < CH_NUM; i++) check(16'(active_code[i]), 16'(code_of(i)), "load");
        $display("async done");
    endtask : t_async
    task automatic t_sync();
        @(posedge sys_clk) load_strobe_n <= 1'b1;
        frame(8'h90, 8'h08, word(10'h155));
        repeat (10) @(posedge sys_clk);
        check(16'(active_code[0]), 16'(code_of(0)), "held");
        load_strobe_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check(16'(active_code[0]), 16'h0155, "strobe load");
        $display("sync done");
    endtask : t_sync
    task automatic t_read();
        logic [7:0] hi;
        logic [7:0] lo;
        logic [2:0] a;
        frame(8'h90, CMD_CFG, 16'h00f0);
        check(16'(power_down), 16'h00f0, "power down bits");
        mst.start();
        mst.put_byte(8'h90, a[2]);
        mst.put_byte(8'h0a, a[1]);
        mst.start();
        mst.put_byte(8'h91, a[0]);
        mst.get_byte(1'b0, hi);
        mst.get_byte(1'b1, lo);
        mst.stop();
        check(16'(a), 16'h0007, "read acks");
        check({hi, lo}, word(code_of(2)), "read back");
        $display("read done");
    endtask : t_read
    task automatic t_resets();
        logic ack;
        logic unused;
        mst.start();
        mst.put_byte(GC_ADDR, ack);
        mst.put_byte(GC_RESET, unused);
        mst.stop();
        check(16'(ack), 16'h1, "general call ack");
        zeros("general call");
        frame(8'h90, 8'h09, word(10'h2aa));
        frame(8'h90, CMD_CFG, 16'h0000);
        frame(8'h90, CMD_TRIG, 16'h000a);
        zeros("soft reset");
        frame(8'h90, 8'h0c, word(10'h3c3));
        @(posedge sys_clk) clear_input_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(16'(active_code !== '0), 16'h0, "clear");
        clear_input_n <= 1'b1;
        $display("resets done");
    endtask : t_resets
    initial begin
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge sys_clk);
        zeros("after reset");
        t_refuse();
        t_async();
        t_sync();
        t_read();
        t_resets();
        report_and_stop();
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("[ERR] %0t timeout", $time);
            report_and_stop();
        end
    end
endmodule : testbench
